// File: hw/fram_cfg.svh
// Constants for the two-wire byte-access nonvolatile memory slave.
`ifndef FRAM_CFG_SVH
`define FRAM_CFG_SVH

// =============================================================
// Array geometry
`define FRAM_ADDR_W 11
`define FRAM_DATA_W 8
`define FRAM_DEPTH 2048

// =============================================================
// Slave address byte layout
`define FRAM_TYPE_HI 7
`define FRAM_TYPE_LO 4
`define FRAM_BLK_HI 3
`define FRAM_BLK_LO 1
`define FRAM_RW_BIT 0
// The device type value is arbitrary.
`define FRAM_DEV_TYPE 4'h6

// =============================================================
// Bit counting and reset values
`define FRAM_LAST_BIT 3'h7
`define FRAM_SCL_RST 1'b1
`define FRAM_SDA_RST 1'b1
`define FRAM_WP_RST 1'b0

`endif

// File: hw/fram_pkg.sv
// Types shared by the memory slave and its array.
`include "fram_cfg.svh"

package fram_pkg;

  // =============================================================
  // Link-side protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV,
    ST_ACK_SET,
    ST_ACK_HOLD,
    ST_WORD,
    ST_WR,
    ST_WR_WAIT,
    ST_RD_LOAD,
    ST_RD_BIT,
    ST_RD_ACK
  } link_state_t;

  // =============================================================
  // Array access request, held stable while a request is open
  typedef struct packed {
    logic                    we;
    logic [`FRAM_ADDR_W-1:0] addr;
    logic [`FRAM_DATA_W-1:0] data;
  } mem_req_t;

endpackage

// File: hw/bit_sync.sv
// Two-flop level synchroniser.
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule // bit_sync

`default_nettype wire

// File: hw/fram_array.sv
// Byte array on the system clock, served by a toggle handshake.
`timescale 1ns/10ps
`default_nettype none
`include "fram_cfg.svh"

module fram_array
  import fram_pkg::*;
#(
  parameter int DEPTH = `FRAM_DEPTH
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    req_tgl_i,
  input  wire mem_req_t                req_i,
  output logic                         done_tgl_o,
  output logic [`FRAM_DATA_W-1:0]      rdata_o
);

  logic                    req_s;
  logic                    do_op;
  logic                    next_done;
  logic [`FRAM_DATA_W-1:0] next_rdata;
  logic [`FRAM_DATA_W-1:0] mem [0:DEPTH-1];

  bit_sync #(.RST_VAL(1'b0)) u_req_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (req_tgl_i),
    .q_o     (req_s)
  );

  // =============================================================
  // A new request shows as a toggle mismatch; the payload is stable.
  always_comb begin
    do_op      = req_s != done_tgl_o;
    next_done  = req_s;
    next_rdata = rdata_o;
    if (do_op && !req_i.we) begin
      next_rdata = mem[req_i.addr];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_tgl_o <= 1'b0;
      rdata_o    <= 8'h00;
    end else begin
      done_tgl_o <= next_done;
      rdata_o    <= next_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_op && req_i.we) begin
      mem[req_i.addr] <= req_i.data;
    end
  end

endmodule // fram_array

`default_nettype wire

// File: hw/i2c_fram_byte_access.sv
// Two-wire slave giving byte access to a 2048-byte nonvolatile array.
// Function
// - Every unprotected write data byte is acknowledged and stored at the next location.
// - Write address counter wraps from the top location to zero.
// - No busy time; a matching slave address is always acknowledged.
// - Byte is stored after its eighth bit, before its acknowledge.
// - START or STOP before the eighth bit drops the byte unwritten.
// - Each byte is committed on its own, no page buffer.
// - Write-protect high: data bytes are neither stored nor acknowledged.
// - A protected byte leaves the address counter unchanged.
// - Write-protect low or undriven means unprotected.
// - Read start is block bits from slave address plus latched low byte.
// - After read address acknowledge, data drives from the next clock.
// - Address advances after each read byte; master ack asks for more.
// - Read address wraps from the top location to zero.
// - Slave byte: type in 7..4, block in 3..1, direction in 0.
// - Word address joins block bits into the eleven-bit latch.
// - All bytes are shifted most significant bit first.
// - STOP aborts any operation and returns to idle.
`timescale 1ns/10ps
`default_nettype none
`include "fram_cfg.svh"

module i2c_fram_byte_access
  import fram_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = `FRAM_DEV_TYPE,
  parameter int         DEPTH    = `FRAM_DEPTH
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic link_clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic wp_i,
  output logic      sda_o,
  output logic      sda_oe_o
);

  // =============================================================
  // Declarations
  link_state_t             state;
  link_state_t             next_state;
  link_state_t             after;
  link_state_t             next_after;
  logic [2:0]              bit_cnt;
  logic [2:0]              next_bit_cnt;
  logic [7:0]              shreg;
  logic [7:0]              next_shreg;
  logic [`FRAM_ADDR_W-1:0] addr;
  logic [`FRAM_ADDR_W-1:0] next_addr;
  logic [2:0]              blk;
  logic [2:0]              next_blk;
  logic                    sda_oe;
  logic                    next_sda_oe;
  logic                    req_tgl;
  logic                    next_req_tgl;
  mem_req_t                req;
  mem_req_t                next_req;
  logic                    scl_d;
  logic                    sda_d;
  logic                    scl_s;
  logic                    sda_s;
  logic                    wp_s;
  logic                    done_s;
  logic                    done_tgl;
  logic [7:0]              rdata;
  logic                    busy;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_c;
  logic                    stop_c;
  logic                    last_rise;
  logic [7:0]              byte_in;

  function automatic logic [`FRAM_ADDR_W-1:0] inc_addr(
    input logic [`FRAM_ADDR_W-1:0] a
  );
    return a + `FRAM_ADDR_W'(1);
  endfunction
  function automatic mem_req_t make_req(
    input logic                    we,
    input logic [`FRAM_ADDR_W-1:0] a,
    input logic [7:0]              d
  );
    return '{we: we, addr: a, data: d};
  endfunction

  // =============================================================
  // Pin and done-toggle synchronisers on the link clock
  bit_sync #(.RST_VAL(`FRAM_SCL_RST)) u_scl_sync (
    .clk_i (link_clk_i), .rst_n_i (rst_n_i), .d_i (scl_i), .q_o (scl_s)
  );
  bit_sync #(.RST_VAL(`FRAM_SDA_RST)) u_sda_sync (
    .clk_i (link_clk_i), .rst_n_i (rst_n_i), .d_i (sda_i), .q_o (sda_s)
  );
  bit_sync #(.RST_VAL(`FRAM_WP_RST)) u_wp_sync (
    .clk_i (link_clk_i), .rst_n_i (rst_n_i), .d_i (wp_i), .q_o (wp_s)
  );
  bit_sync #(.RST_VAL(1'b0)) u_done_sync (
    .clk_i (link_clk_i), .rst_n_i (rst_n_i), .d_i (done_tgl), .q_o (done_s)
  );

  // =============================================================
  // Array on the system clock
  fram_array #(.DEPTH(DEPTH)) u_array (
    .clk_i (clk_i), .rst_n_i (rst_n_i), .req_tgl_i (req_tgl),
    .req_i (req), .done_tgl_o (done_tgl), .rdata_o (rdata)
  );

  // =============================================================
  // Bus conditions
  always_comb begin
    scl_rise  = scl_s && !scl_d;
    scl_fall  = !scl_s && scl_d;
    start_c   = scl_s && scl_d && sda_d && !sda_s;
    stop_c    = scl_s && scl_d && !sda_d && sda_s;
    byte_in   = {shreg[6:0], sda_s};
    last_rise = scl_rise && (bit_cnt == `FRAM_LAST_BIT);
    busy      = req_tgl != done_s;
  end

  // =============================================================
  // Protocol engine
  always_comb begin
    next_state   = state;
    next_after   = after;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_addr    = addr;
    next_blk     = blk;
    next_sda_oe  = sda_oe;
    next_req_tgl = req_tgl;
    next_req     = req;
    if (stop_c) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_c) begin
      next_state   = ST_DEV;
      next_bit_cnt = 3'h0;
      next_sda_oe  = 1'b0;
    end else begin
      // Address, word and write bytes shift in on every sampled rise.
      if (scl_rise && (state == ST_DEV || state == ST_WORD ||
          state == ST_WR)) begin
        next_shreg   = byte_in;
        next_bit_cnt = bit_cnt + 3'h1;
      end
      case (state)
        ST_DEV: begin
          if (last_rise) begin
            if (byte_in[`FRAM_TYPE_HI:`FRAM_TYPE_LO] != DEV_TYPE) begin
              next_state = ST_IDLE;
            end else begin
              next_blk   = byte_in[`FRAM_BLK_HI:`FRAM_BLK_LO];
              next_state = ST_ACK_SET;
              next_after = ST_WORD;
              if (byte_in[`FRAM_RW_BIT]) begin
                next_addr = {byte_in[`FRAM_BLK_HI:`FRAM_BLK_LO], addr[7:0]};
                next_req  = make_req(1'b0, next_addr, 8'h00);
                next_req_tgl = ~req_tgl;
                next_after   = ST_RD_LOAD;
              end
            end
          end
        end
        ST_ACK_SET: begin
          if (!scl_s) begin
            next_sda_oe  = 1'b1;
            next_bit_cnt = 3'h0;
            next_state   = ST_ACK_HOLD;
          end
        end
        ST_ACK_HOLD: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state  = after;
          end
        end
        ST_WORD: begin
          if (last_rise) begin
            next_addr  = {blk, byte_in};
            next_after = ST_WR;
            next_state = ST_ACK_SET;
          end
        end
        ST_WR: begin
          if (last_rise) begin
            if (wp_s) begin
              next_state = ST_IDLE;
            end else begin
              next_req     = make_req(1'b1, addr, byte_in);
              next_req_tgl = ~req_tgl;
              next_state   = ST_WR_WAIT;
            end
          end
        end
        ST_WR_WAIT: begin
          if (!busy) begin
            next_addr  = inc_addr(addr);
            next_after = ST_WR;
            next_state = ST_ACK_SET;
          end
        end
        ST_RD_LOAD: begin
          if (!scl_s && !busy) begin
            next_shreg   = rdata;
            next_sda_oe  = !rdata[7];
            next_bit_cnt = 3'h0;
            next_addr    = inc_addr(addr);
            next_req     = make_req(1'b0, inc_addr(addr), 8'h00);
            next_req_tgl = ~req_tgl;
            next_state   = ST_RD_BIT;
          end
        end
        ST_RD_BIT: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `FRAM_LAST_BIT) begin
              next_sda_oe = 1'b0;
              next_state  = ST_RD_ACK;
            end else begin
              next_sda_oe = !shreg[6];
              next_shreg  = {shreg[6:0], 1'b0};
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_state = sda_s ? ST_IDLE : ST_RD_LOAD;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= ST_IDLE;
      after   <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg   <= 8'h00;
      addr    <= 11'h000;
      blk     <= 3'h0;
      sda_oe  <= 1'b0;
      req_tgl <= 1'b0;
      req     <= '0;
      scl_d   <= `FRAM_SCL_RST;
      sda_d   <= `FRAM_SDA_RST;
    end else begin
      state   <= next_state;
      after   <= next_after;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      addr    <= next_addr;
      blk     <= next_blk;
      sda_oe  <= next_sda_oe;
      req_tgl <= next_req_tgl;
      req     <= next_req;
      scl_d   <= scl_s;
      sda_d   <= sda_s;
    end
  end
  // The pin is open drain: it only ever pulls low.
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe;

  // =============================================================
  // Checks
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr_byte_done;
    state == ST_WR && last_rise && !wp_s && !start_c && !stop_c;
  endsequence
  sequence s_addr_byte_foreign;
    state == ST_DEV && last_rise && !start_c && !stop_c &&
      byte_in[7:4] != DEV_TYPE;
  endsequence
  stop_to_idle_a: assert property (
    stop_c |=> state == ST_IDLE && !sda_oe
  ) else $error("STOP did not return the engine to idle");
  foreign_ignored_a: assert property (
    s_addr_byte_foreign |=> state == ST_IDLE ##1 !sda_oe
  ) else $error("Foreign slave address was not ignored");
  protect_refuse_a: assert property (
    (state == ST_WR && last_rise && wp_s && !start_c && !stop_c)
      |=> state == ST_IDLE && !sda_oe && $stable(req_tgl)
  ) else $error("Protected byte was stored or acknowledged");
  protect_addr_a: assert property (
    (state == ST_WR && last_rise && wp_s && !start_c && !stop_c)
      |=> $stable(addr)
  ) else $error("Address moved on a protected byte");
  wr_commit_a: assert property (
    s_wr_byte_done |=> req.we && req.data == $past(byte_in) &&
      req_tgl != $past(req_tgl)
  ) else $error("Write byte was not committed on its own");
  store_before_ack_a: assert property (
    $rose(sda_oe) && after == ST_WR |-> !busy
  ) else $error("Acknowledge driven before the store finished");
  wr_advance_a: assert property (
    (state == ST_WR_WAIT && !busy && !start_c && !stop_c)
      |=> addr == $past(addr) + 11'h001
  ) else $error("Write address did not advance with wrap");
  rd_start_a: assert property (
    (state == ST_DEV && last_rise && !start_c && !stop_c &&
      byte_in[7:4] == DEV_TYPE && byte_in[0])
      |=> addr == {$past(byte_in[3:1]), $past(addr[7:0])}
  ) else $error("Read start address formed wrongly");
  rd_first_bit_a: assert property (
    (state == ST_RD_LOAD && !scl_s && !busy && !start_c && !stop_c)
      |=> sda_oe == !shreg[7] && state == ST_RD_BIT &&
        addr == $past(addr) + 11'h001
  ) else $error("Read data not driven or address not advanced");
  addr_ack_a: assert property (
    (state == ST_ACK_SET && !scl_s && !start_c && !stop_c) |=> sda_oe
  ) else $error("Acknowledge was not driven");

endmodule // i2c_fram_byte_access

`default_nettype wire

// File: bench/i2c_master_model.sv
// Behavioural two-wire bus master that drives the serial clock and data.
`timescale 1ns/10ps
`default_nettype none

module i2c_master_model #(
  parameter int HALF = 160
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // =============================================================
  // Bus conditions
  // The serial clock idles high and stands still between frames.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge clk_i);
  endtask

  task automatic start_cond();
    @(posedge clk_i);
    sda_low_o <= 1'b0;
    wait_half();
    scl_o <= 1'b1;
    wait_half();
    sda_low_o <= 1'b1;
    wait_half();
    scl_o <= 1'b0;
  endtask

  task automatic stop_cond();
    @(posedge clk_i);
    sda_low_o <= 1'b1;
    wait_half();
    scl_o <= 1'b1;
    wait_half();
    sda_low_o <= 1'b0;
    wait_half();
  endtask

  // Data changes only while the clock is low and is sampled late in the high.
  task automatic bit_xfer(input logic b, output logic s);
    @(posedge clk_i);
    sda_low_o <= ~b;
    wait_half();
    scl_o <= 1'b1;
    wait_half();
    s = sda_i;
    scl_o <= 1'b0;
  endtask

  // =============================================================
  // Byte transfers
  // MSB first shifting.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = (s === 1'b0);
  endtask

  // Read ending choices.
  // Mode 1 acknowledges, mode 0 refuses, mode 2 leaves the ninth clock open.
  task automatic rd_byte(input int mode, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    if (mode < 2) bit_xfer(mode != 1, s);
  endtask
endmodule // i2c_master_model

`default_nettype wire

// File: bench/i2c_fram_byte_access_bench.sv
// Self-checking bench for the two-wire byte-access memory slave.
`timescale 1ns/10ps
`default_nettype none
`include "fram_cfg.svh"

module i2c_fram_byte_access_bench;
  localparam logic [23:0] PAT = 24'hA53C5A;

  logic clk;
  logic rst_n;
  logic link_clk;
  logic wp;
  wire  scl;
  wire  sda_low;
  wire  sda;
  logic sda_out;
  logic sda_oe;
  int   error_cnt = 0;
  int   samples_checked = 0;

  // =============================================================
  // Clocks and wiring
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // The link clock is offset so its edges never meet the system clock.
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #62.5 link_clk = ~link_clk;
  end
  assign sda = ~((sda_oe & ~sda_out) | sda_low);

  i2c_fram_byte_access i2c_fram_byte_access_i (
    .clk_i      (clk),
    .rst_n_i    (rst_n),
    .link_clk_i (link_clk),
    .scl_i      (scl),
    .sda_i      (sda),
    .wp_i       (wp),
    .sda_o      (sda_out),
    .sda_oe_o   (sda_oe)
  );

  i2c_master_model i2c_master_model_i (
    .clk_i     (clk),
    .sda_i     (sda),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  // =============================================================
  // Compare and helper tasks
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] sa(input logic [2:0] blk, input logic rw);
    return {`FRAM_DEV_TYPE, blk, rw};
  endfunction

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic ack;
    i2c_master_model_i.wr_byte(d, ack);
    check_bit(ack, exp_ack);
  endtask

  task automatic fetch(input int mode, input logic [7:0] exp);
    logic [7:0] d;
    i2c_master_model_i.rd_byte(mode, d);
    check_byte(d, exp);
  endtask

  // =============================================================
  // Scenarios
  task automatic write_wrap();
    i2c_master_model_i.start_cond();
    send(sa(3'h7, 1'b0), 1'b1);
    send(8'hFE, 1'b1);
    for (int i = 0; i < 3; i++) send(PAT[23-8*i -: 8], 1'b1);
    i2c_master_model_i.stop_cond();
    i2c_master_model_i.start_cond();
    send(sa(3'h0, 1'b0), 1'b1);
    i2c_master_model_i.stop_cond();
  endtask

  task automatic random_read();
    i2c_master_model_i.start_cond();
    send(sa(3'h7, 1'b0), 1'b1);
    send(8'hFE, 1'b1);
    i2c_master_model_i.start_cond();
    send(sa(3'h7, 1'b1), 1'b1);
    for (int i = 0; i < 3; i++) fetch(i < 2, PAT[23-8*i -: 8]);
    i2c_master_model_i.stop_cond();
  endtask

  task automatic protect();
    @(posedge clk);
    wp <= 1'b1;
    i2c_master_model_i.start_cond();
    send(sa(3'h0, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(8'h77, 1'b0);
    i2c_master_model_i.stop_cond();
    @(posedge clk);
    wp <= 1'b0;
    i2c_master_model_i.start_cond();
    send(sa(3'h0, 1'b1), 1'b1);
    fetch(0, 8'h5A);
    i2c_master_model_i.stop_cond();
  endtask

  task automatic abort_write();
    logic s;
    i2c_master_model_i.start_cond();
    send(sa(3'h0, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    for (int i = 0; i < 4; i++) i2c_master_model_i.bit_xfer(1'b0, s);
    i2c_master_model_i.stop_cond();
    i2c_master_model_i.start_cond();
    send(sa(3'h0, 1'b1), 1'b1);
    fetch(2, 8'h5A);
    i2c_master_model_i.stop_cond();
    repeat (40) @(posedge clk);
    check_bit(sda_oe, 1'b0);
  endtask

  task automatic foreign();
    i2c_master_model_i.start_cond();
    send({~`FRAM_DEV_TYPE, 3'h0, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    i2c_master_model_i.stop_cond();
    i2c_master_model_i.start_cond();
    send(sa(3'h0, 1'b0), 1'b1);
    i2c_master_model_i.stop_cond();
  endtask

  // =============================================================
  // Main sequence and watchdog
  // Reset covers one rising link clock edge; the synchronisers then settle.
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (80) @(posedge clk);
    write_wrap();
    random_read();
    protect();
    abort_write();
    foreign();
    results();
  end

  // A clean run takes about 80,000 system clocks.
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule // i2c_fram_byte_access_bench

`default_nettype wire
